// >>> hw/scan_instruction_decoder.sv
// Instruction decoder of a boundary-scan test port
`timescale 1ns/1ps

// Notes on behaviour
// RULE1 - Eight-bit opcode; bit 7 keeps even parity across the whole code.
// RULE2 - Unsupported or unlisted opcodes act exactly as bypass, normal mode.
// RULE3 - Codes 00 and 03 select boundary; capture pins and core outputs.
// RULE4 - Boundary test runs in test mode; scanned cells drive core and pins.
// RULE5 - Bypass puts one-bit register in path, captures zero, normal mode.
// RULE6 - Sample/preload selects boundary, captures pins and core, normal mode.
// RULE7 - High-impedance selects bypass, floats I/O pins, core keeps running; the code puts it in test mode instead.
// RULE8 - Clamp selects bypass capturing zero; cells drive core and pins.
// RULE9 - Run test selects bypass, test mode, runs control-selected op in idle.
// RULE10 - Boundary read codes leave boundary contents unchanged at capture.
// RULE11 - Cell self-check selects boundary; cells capture their complement.
// RULE12 - Toggle outputs: shift stages invert on rise, latch on fall, idle.
// RULE13 - Toggle outputs holds input cells, no pin capture, bypass gets zero.
// RULE14 - Control scan codes select eleven-bit control register, no capture.
// RULE15 - Controller loads control register before issuing run test.
// RULE16 - Decoded instruction selects normal or test mode.
// RULE17 - Capture-IR loads pattern 10000001 into instruction shift register.
// RULE18 - New instruction and mode act on falling edge in update-IR.
module scan_instruction_decoder (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Test pins and controller state levels, all from the test clock side
  input wire logic tck,
  input wire logic tdi,
  input wire logic st_logic_reset,
  input wire logic st_capture_ir,
  input wire logic st_shift_ir,
  input wire logic st_update_ir,
  input wire logic st_capture_dr,
  input wire logic st_shift_dr,
  input wire logic st_run_idle,
  // Serial output of boundary or control register and control opcode
  input wire logic dr_serial_out,
  input wire logic [2:0] control_op,
  // Path selection and mode
  output logic sel_boundary_reg,
  output logic sel_bypass_reg,
  output logic sel_control_reg,
  output logic test_mode_reg,
  output logic highz_reg,
  output logic hold_inputs_reg,
  // Capture and run strobes toward the boundary register
  output logic capture_pins_reg,
  output logic capture_invert_reg,
  output logic toggle_step_reg,
  output logic output_latch_reg,
  output logic run_step_reg,
  output logic [2:0] run_op_reg,
  // Serial output
  output logic bypass_bit_reg,
  output logic tdo_reg,
  output logic tdo_oe_reg
);

  // ---------------------------------------------------------------
  // Opcode decode
  // ---------------------------------------------------------------
  // Full eight-bit compare: a code with wrong parity matches nothing
  // and so falls to bypass.
  function automatic scan_decoder_pkg::instr_t decode(
    input logic [7:0] opc
  );
    case (opc)
      scan_decoder_pkg::OPC_BOUNDARY_A:
        decode = scan_decoder_pkg::INS_BOUNDARY;
      scan_decoder_pkg::OPC_BOUNDARY_B:
        decode = scan_decoder_pkg::INS_BOUNDARY;
      scan_decoder_pkg::OPC_SAMPLE: decode = scan_decoder_pkg::INS_SAMPLE;
      scan_decoder_pkg::OPC_HIGHZ: decode = scan_decoder_pkg::INS_HIGHZ;
      scan_decoder_pkg::OPC_CLAMP: decode = scan_decoder_pkg::INS_CLAMP;
      scan_decoder_pkg::OPC_RUN_TEST: decode = scan_decoder_pkg::INS_RUN_TEST;
      scan_decoder_pkg::OPC_READ_NORMAL:
        decode = scan_decoder_pkg::INS_READ_NORMAL;
      scan_decoder_pkg::OPC_READ_TEST:
        decode = scan_decoder_pkg::INS_READ_TEST;
      scan_decoder_pkg::OPC_SELF_CHECK:
        decode = scan_decoder_pkg::INS_SELF_CHECK;
      scan_decoder_pkg::OPC_TOGGLE: decode = scan_decoder_pkg::INS_TOGGLE;
      scan_decoder_pkg::OPC_CTL_NORMAL:
        decode = scan_decoder_pkg::INS_CTL_NORMAL;
      scan_decoder_pkg::OPC_CTL_TEST: decode = scan_decoder_pkg::INS_CTL_TEST;
      default: decode = scan_decoder_pkg::INS_BYPASS; // RULE1 RULE2
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic [9:0] raw_in;
  logic [9:0] sync1_reg;
  logic [9:0] sync2_reg;
  logic [9:0] sync3_reg;

  assign raw_in = {dr_serial_out, st_run_idle, st_shift_dr, st_capture_dr,
                   st_update_ir, st_shift_ir, st_capture_ir,
                   st_logic_reset, tdi, tck};

  // Third stage holds the pre-edge view of the states, since the
  // controller moves on the very rising edge that is detected.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  logic [2:0] op_sync1_reg;
  logic [2:0] op_sync2_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      op_sync1_reg <= '0;
      op_sync2_reg <= '0;
    end else begin
      op_sync1_reg <= control_op;
      op_sync2_reg <= op_sync1_reg;
    end
  end

  wire tck_rise = sync2_reg[scan_decoder_pkg::SY_TCK] &&
                  !sync3_reg[scan_decoder_pkg::SY_TCK];
  wire tck_fall = !sync2_reg[scan_decoder_pkg::SY_TCK] &&
                  sync3_reg[scan_decoder_pkg::SY_TCK];
  wire in_reset = sync3_reg[scan_decoder_pkg::SY_RESET];
  wire in_cap_ir = sync3_reg[scan_decoder_pkg::SY_CAP_IR];
  wire in_shift_ir = sync3_reg[scan_decoder_pkg::SY_SHIFT_IR];
  wire in_upd_ir = sync3_reg[scan_decoder_pkg::SY_UPD_IR];
  wire in_cap_dr = sync3_reg[scan_decoder_pkg::SY_CAP_DR];
  wire in_shift_dr = sync3_reg[scan_decoder_pkg::SY_SHIFT_DR];
  wire in_idle = sync3_reg[scan_decoder_pkg::SY_IDLE];
  wire tdi_s = sync3_reg[scan_decoder_pkg::SY_TDI];
  wire dr_out_s = sync3_reg[scan_decoder_pkg::SY_DR_SERIAL];

  // ---------------------------------------------------------------
  // Instruction register
  // ---------------------------------------------------------------
  logic ir_lsb;
  logic [7:0] instr;

  instruction_shift u_ir (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tck_rise(tck_rise),
    .tck_fall(tck_fall),
    .logic_reset(in_reset),
    .capture_ir(in_cap_ir),
    .shift_ir(in_shift_ir),
    .update_ir(in_upd_ir),
    .tdi(tdi_s),
    .shift_lsb(ir_lsb),
    .instr_out(instr)
  );

  // ---------------------------------------------------------------
  // Decoded controls
  // ---------------------------------------------------------------
  scan_decoder_pkg::instr_t ins;
  assign ins = decode(instr);

  wire ins_boundary = ins == scan_decoder_pkg::INS_BOUNDARY;
  wire ins_sample = ins == scan_decoder_pkg::INS_SAMPLE;
  wire ins_run = ins == scan_decoder_pkg::INS_RUN_TEST;
  wire ins_toggle = ins == scan_decoder_pkg::INS_TOGGLE;
  wire ins_self = ins == scan_decoder_pkg::INS_SELF_CHECK;
  wire ins_highz = ins == scan_decoder_pkg::INS_HIGHZ;

  wire sel_boundary_next = ins_boundary || ins_sample || ins_self ||
                           ins == scan_decoder_pkg::INS_READ_NORMAL ||
                           ins == scan_decoder_pkg::INS_READ_TEST;
  wire sel_control_next = ins == scan_decoder_pkg::INS_CTL_NORMAL ||
                          ins == scan_decoder_pkg::INS_CTL_TEST;
  wire test_mode_next = ins_boundary || ins_highz || ins_run ||
                        ins_toggle ||
                        ins == scan_decoder_pkg::INS_CLAMP ||
                        ins == scan_decoder_pkg::INS_READ_TEST ||
                        ins == scan_decoder_pkg::INS_CTL_TEST;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sel_boundary_reg <= 1'b0;
      sel_bypass_reg <= 1'b1;
      sel_control_reg <= 1'b0;
      test_mode_reg <= 1'b0;
      highz_reg <= 1'b0;
      hold_inputs_reg <= 1'b0;
    end else begin
      sel_boundary_reg <= sel_boundary_next; // RULE3 RULE6 RULE10 RULE11
      sel_control_reg <= sel_control_next; // RULE14
      sel_bypass_reg <= !sel_boundary_next && !sel_control_next; // RULE5
      test_mode_reg <= test_mode_next; // RULE4 RULE8 RULE9 RULE16
      highz_reg <= ins_highz; // RULE7
      hold_inputs_reg <= ins_toggle; // RULE13
    end
  end

  // ---------------------------------------------------------------
  // Capture and run strobes
  // ---------------------------------------------------------------
  // Read and control-scan codes raise no capture strobe at all, which
  // is how their contents survive capture for readout.
  wire cap_edge = tck_rise && in_cap_dr;
  wire idle_rise = tck_rise && in_idle;
  wire idle_fall = tck_fall && in_idle;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      capture_pins_reg <= 1'b0;
      capture_invert_reg <= 1'b0;
      toggle_step_reg <= 1'b0;
      output_latch_reg <= 1'b0;
      run_step_reg <= 1'b0;
      run_op_reg <= '0;
    end else begin
      capture_pins_reg <= cap_edge && (ins_boundary || ins_sample); // RULE3
      capture_invert_reg <= cap_edge && ins_self; // RULE11
      toggle_step_reg <= idle_rise && ins_toggle; // RULE12
      output_latch_reg <= idle_fall && (ins_toggle || ins_run); // RULE12
      run_step_reg <= idle_rise && ins_run; // RULE9
      run_op_reg <= op_sync2_reg; // RULE15
    end
  end

  // ---------------------------------------------------------------
  // Bypass register and serial output
  // ---------------------------------------------------------------
  wire bypass_path = !sel_boundary_next && !sel_control_next;
  wire tdo_next = in_shift_ir ? ir_lsb :
                  bypass_path ? bypass_bit_reg : dr_out_s;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || in_reset) begin
      bypass_bit_reg <= scan_decoder_pkg::BYPASS_CAPTURE;
    end else if (tck_rise && bypass_path) begin
      if (in_cap_dr) begin
        bypass_bit_reg <= scan_decoder_pkg::BYPASS_CAPTURE; // RULE5 RULE13
      end else if (in_shift_dr) begin
        bypass_bit_reg <= tdi_s;
      end
    end
  end

  // Output changes only on the falling edge, as the pin timing demands
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (tck_fall) begin
      tdo_reg <= tdo_next; // RULE17
      tdo_oe_reg <= in_shift_ir || in_shift_dr;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_parity_bypass: assert property ( // RULE1
    (^instr) |=> sel_bypass_reg && !test_mode_reg)
    else $error("odd parity opcode not decoded as bypass");

  chk_unlisted_bypass: assert property ( // RULE2
    (instr == 8'h84 || instr == 8'h05 || instr == 8'h88)
      |=> sel_bypass_reg && !test_mode_reg && !highz_reg)
    else $error("unsupported opcode not treated as bypass");

  chk_boundary_capture: assert property ( // RULE3
    (cap_edge && (instr == 8'h00 || instr == 8'h03)) |=> capture_pins_reg)
    else $error("boundary capture strobe missing");

  chk_bypass_zero: assert property ( // RULE5
    (cap_edge && bypass_path && !in_reset) |=> bypass_bit_reg == 1'b0)
    else $error("bypass did not capture zero");

  chk_highz_mode: assert property ( // RULE7
    (instr == 8'h06) |=> highz_reg && test_mode_reg && sel_bypass_reg)
    else $error("high impedance decode wrong");

  chk_run_step: assert property ( // RULE9
    (idle_rise && instr == 8'h09) |=> run_step_reg && test_mode_reg)
    else $error("run step not issued in idle");

  chk_read_nocapture: assert property ( // RULE10
    (cap_edge && (instr == 8'h0A || instr == 8'h8B))
      |=> !capture_pins_reg && !capture_invert_reg && sel_boundary_reg)
    else $error("boundary read disturbed contents");

  chk_self_invert: assert property ( // RULE11
    (cap_edge && instr == 8'h0C) |=> capture_invert_reg && !test_mode_reg)
    else $error("self check did not invert");

  chk_toggle_hold: assert property ( // RULE13
    (instr == 8'h8D) |=> hold_inputs_reg && !capture_pins_reg
      && sel_bypass_reg)
    else $error("toggle outputs did not hold inputs");

  chk_control_path: assert property ( // RULE14
    (instr == 8'h8E || instr == 8'h0F) |=> sel_control_reg
      && !capture_pins_reg && !capture_invert_reg)
    else $error("control register path wrong");

  chk_ir_capture: assert property ( // RULE17
    (tck_rise && in_cap_ir && !in_shift_ir && !in_reset)
      |=> u_ir.shift_reg == 8'h81)
    else $error("capture pattern not loaded");

  chk_update_fall: assert property ( // RULE18
    ($changed(instr) && !$past(in_reset)) |-> $past(tck_fall && in_upd_ir))
    else $error("instruction changed outside update fall");

endmodule

// >>> hw/scan_decoder_pkg.sv
// Constants and types shared by the scan instruction decoder
package scan_decoder_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int IR_WIDTH = 8;
  localparam int OP_WIDTH = 3;
  localparam int SYNC_WIDTH = 10;
  localparam int PARITY_BIT = 7;

  // ---------------------------------------------------------------
  // Instruction register values
  // ---------------------------------------------------------------
  localparam logic [7:0] IR_CAPTURE_VALUE = 8'h81;
  localparam logic [7:0] IR_RESET_VALUE = 8'hFF;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_BOUNDARY_A = 8'h00;
  localparam logic [7:0] OPC_BOUNDARY_B = 8'h03;
  localparam logic [7:0] OPC_SAMPLE = 8'h82;
  localparam logic [7:0] OPC_HIGHZ = 8'h06;
  localparam logic [7:0] OPC_CLAMP = 8'h87;
  localparam logic [7:0] OPC_RUN_TEST = 8'h09;
  localparam logic [7:0] OPC_READ_NORMAL = 8'h0A;
  localparam logic [7:0] OPC_READ_TEST = 8'h8B;
  localparam logic [7:0] OPC_SELF_CHECK = 8'h0C;
  localparam logic [7:0] OPC_TOGGLE = 8'h8D;
  localparam logic [7:0] OPC_CTL_NORMAL = 8'h8E;
  localparam logic [7:0] OPC_CTL_TEST = 8'h0F;

  // ---------------------------------------------------------------
  // Bypass capture value and synchroniser input positions
  // ---------------------------------------------------------------
  localparam logic BYPASS_CAPTURE = 1'b0;
  localparam int SY_TCK = 0;
  localparam int SY_TDI = 1;
  localparam int SY_RESET = 2;
  localparam int SY_CAP_IR = 3;
  localparam int SY_SHIFT_IR = 4;
  localparam int SY_UPD_IR = 5;
  localparam int SY_CAP_DR = 6;
  localparam int SY_SHIFT_DR = 7;
  localparam int SY_IDLE = 8;
  localparam int SY_DR_SERIAL = 9;

  typedef enum logic [3:0] {
    INS_BOUNDARY,
    INS_BYPASS,
    INS_SAMPLE,
    INS_HIGHZ,
    INS_CLAMP,
    INS_RUN_TEST,
    INS_READ_NORMAL,
    INS_READ_TEST,
    INS_SELF_CHECK,
    INS_TOGGLE,
    INS_CTL_NORMAL,
    INS_CTL_TEST
  } instr_t;

endpackage

// >>> hw/instruction_shift.sv
// Instruction shift register with its update shadow
`timescale 1ns/1ps

module instruction_shift (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Test clock edges and controller states
  input wire logic tck_rise,
  input wire logic tck_fall,
  input wire logic logic_reset,
  input wire logic capture_ir,
  input wire logic shift_ir,
  input wire logic update_ir,
  input wire logic tdi,
  // Results
  output logic shift_lsb,
  output logic [7:0] instr_out
);

  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] shadow_reg;

  assign shift_next = shift_ir ? {tdi, shift_reg[7:1]} :
                      capture_ir ? scan_decoder_pkg::IR_CAPTURE_VALUE :
                      shift_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || logic_reset) begin
      shift_reg <= scan_decoder_pkg::IR_RESET_VALUE;
    end else if (tck_rise) begin
      shift_reg <= shift_next; // RULE17
    end
  end

  // Shadow only moves on the falling edge, so decode never sees a
  // half-shifted opcode.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || logic_reset) begin
      shadow_reg <= scan_decoder_pkg::IR_RESET_VALUE;
    end else if (tck_fall && update_ir) begin
      shadow_reg <= shift_reg; // RULE18
    end
  end

  assign shift_lsb = shift_reg[0];
  assign instr_out = shadow_reg;

endmodule

// >>> testbench/tap_controller_model.sv
// Behavioural scan controller that drives the decoder's test port
`timescale 1ns/1ps

module tap_controller_model (
  // Clock
  input wire logic ref_clk,
  // Test port
  output logic tck,
  output logic tdi,
  output logic [6:0] st,
  input wire logic tdo_reg,
  input wire logic tdo_oe_reg
);
  // st bits: reset, cap_ir, shift_ir, upd_ir, cap_dr, shift_dr, idle
  time t_upd_fall = 0;

  initial begin
    tck = 1'b0;
    tdi = 1'b0;
    st = 7'h01;
  end

  // ---------------------------------------------------------------
  // One 400 ns test clock; the state moves with the rise
  // ---------------------------------------------------------------
  // Unused tdi is inverted so a stale level never looks valid
  task automatic tick(input logic [6:0] nxt, input logic d,
                      output logic [1:0] q);
    tdi = d;
    repeat (4) @(negedge ref_clk);
    q = {tdo_oe_reg, tdo_reg};
    tck = 1'b1;
    st = nxt;
    repeat (4) @(negedge ref_clk);
    tck = 1'b0;
    if (st[3]) t_upd_fall = $time;
  endtask

  // ---------------------------------------------------------------
  // Scans
  // ---------------------------------------------------------------
  task automatic ir_scan(input logic [7:0] op, output logic [7:0] cap,
                         output logic [7:0] oe);
    logic [1:0] q;
    tick(7'h00, ~tdi, q);
    tick(7'h00, ~tdi, q);
    tick(7'h20, ~tdi, q);
    tick(7'h10, ~tdi, q);
    for (int k = 0; k < 8; k++) begin
      tick((k < 7) ? 7'h10 : 7'h00, op[k], q);
      cap[k] = q[0];
      oe[k] = q[1];
    end
    tick(7'h08, ~tdi, q);
    tick(7'h01, ~tdi, q);
  endtask

  task automatic dr_scan(input int n, input logic d,
                         output logic [7:0] dout);
    logic [1:0] q;
    dout = 8'h00;
    tick(7'h00, ~tdi, q);
    tick(7'h04, ~tdi, q);
    tick(7'h02, ~tdi, q);
    for (int k = 0; k < n; k++) begin
      tick((k < n - 1) ? 7'h02 : 7'h00, d, q);
      dout[k] = q[0];
    end
    tick(7'h00, ~tdi, q);
    tick(7'h01, ~tdi, q);
  endtask
endmodule

// >>> testbench/scan_instruction_decoder_bench.sv
// Self-checking bench for the scan instruction decoder
`timescale 1ns/1ps

module scan_instruction_decoder_bench;
  logic ref_clk;
  logic sys_rst;
  logic dr_serial_out;
  logic [2:0] control_op;
  logic tck, tdi;
  logic [6:0] st;
  logic sel_boundary_reg, sel_bypass_reg, sel_control_reg, test_mode_reg;
  logic highz_reg, hold_inputs_reg, capture_pins_reg, capture_invert_reg;
  logic toggle_step_reg, output_latch_reg, run_step_reg;
  logic bypass_bit_reg, tdo_reg, tdo_oe_reg;
  logic [2:0] run_op_reg;
  int n_fail = 0;
  int checked = 0;
  int cnt [5] = '{0, 0, 0, 0, 0};
  time t_sel = 0;
  logic sb_q = 1'b0;
  wire [7:0] lv = {sel_boundary_reg, sel_bypass_reg, sel_control_reg,
    test_mode_reg, highz_reg, hold_inputs_reg, 2'b00};
  // Expected: boundary, bypass, control, test, highz, hold, pins, invert
  // Last code has odd parity, so it must fall to bypass
  localparam logic [7:0] OPS [19] = '{8'h00, 8'h03, 8'h82, 8'h81, 8'h84,
    8'h05, 8'h88, 8'hFF, 8'h5A, 8'h06, 8'h87, 8'h09, 8'h0A, 8'h8B, 8'h0C,
    8'h8D, 8'h8E, 8'h0F, 8'h8C};
  localparam logic [7:0] EXP [19] = '{8'h92, 8'h92, 8'h82, 8'h40, 8'h40,
    8'h40, 8'h40, 8'h40, 8'h40, 8'h58, 8'h50, 8'h50, 8'h80, 8'h90, 8'h81,
    8'h54, 8'h20, 8'h30, 8'h40};

  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------
  // Design and controller
  // ---------------------------------------------------------------
  scan_instruction_decoder uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .tck(tck), .tdi(tdi),
    .st_logic_reset(st[6]), .st_capture_ir(st[5]), .st_shift_ir(st[4]),
    .st_update_ir(st[3]), .st_capture_dr(st[2]), .st_shift_dr(st[1]),
    .st_run_idle(st[0]), .dr_serial_out(dr_serial_out),
    .control_op(control_op), .sel_boundary_reg(sel_boundary_reg),
    .sel_bypass_reg(sel_bypass_reg), .sel_control_reg(sel_control_reg),
    .test_mode_reg(test_mode_reg), .highz_reg(highz_reg),
    .hold_inputs_reg(hold_inputs_reg), .capture_pins_reg(capture_pins_reg),
    .capture_invert_reg(capture_invert_reg),
    .toggle_step_reg(toggle_step_reg), .output_latch_reg(output_latch_reg),
    .run_step_reg(run_step_reg), .run_op_reg(run_op_reg),
    .bypass_bit_reg(bypass_bit_reg), .tdo_reg(tdo_reg),
    .tdo_oe_reg(tdo_oe_reg)
  );

  tap_controller_model ctl (
    .ref_clk(ref_clk), .tck(tck), .tdi(tdi), .st(st),
    .tdo_reg(tdo_reg), .tdo_oe_reg(tdo_oe_reg)
  );

  // Pulses are counted so that one-cycle strobes are never missed
  always @(posedge ref_clk) begin
    cnt[0] += int'(capture_pins_reg === 1'b1);
    cnt[1] += int'(capture_invert_reg === 1'b1);
    cnt[2] += int'(toggle_step_reg === 1'b1);
    cnt[3] += int'(output_latch_reg === 1'b1);
    cnt[4] += int'(run_step_reg === 1'b1);
    if (sel_boundary_reg !== sb_q) t_sel = $time;
    sb_q = sel_boundary_reg;
  end

  // ---------------------------------------------------------------
  // Compare and report
  // ---------------------------------------------------------------
  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp,
                       input string m);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp, input string m);
    checked++;
    if (got != exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask

  task automatic clr();
    foreach (cnt[i]) cnt[i] = 0;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_table();
    logic [7:0] cap, oe, dout, e, p, x;
    p = 8'h40;
    for (int i = 0; i < 19; i++) begin
      e = EXP[i];
      ctl.ir_scan(OPS[i], cap, oe);
      chk_v(cap, 8'h81, "ir capture");
      chk_v(oe, 8'hFF, "shift enable");
      chk_v({7'h00, tdo_oe_reg}, 8'h00, "idle enable");
      chk_v(lv, e & 8'hFC, "decode");
      if (e[7] != p[7]) chk_n(int'((t_sel > ctl.t_upd_fall) &&
        (t_sel <= ctl.t_upd_fall + 400)), 1, "update edge");
      clr();
      // Bypass holds a 1 from the previous scan, so the zero is captured
      // Far register output alternates so a stuck serial path shows up
      dr_serial_out = i[0];
      x = e[6] ? 8'h02 : {6'h00, i[0], i[0]};
      ctl.dr_scan(2, 1'b1, dout);
      chk_v(dout, x, "dr out");
      if (e[6]) chk_v({7'h00, bypass_bit_reg}, 8'h01, "bypass shift");
      chk_n(cnt[0], int'(e[1]), "pin capture");
      chk_n(cnt[1], int'(e[0]), "invert capture");
      p = e;
    end
    $display("decode table done");
  endtask

  task automatic test_idle(input logic [7:0] op, input int et,
                           input int er);
    logic [7:0] cap, oe, dout;
    logic [1:0] q;
    ctl.ir_scan(8'h8E, cap, oe);
    ctl.dr_scan(8, 1'b0, dout);
    ctl.ir_scan(op, cap, oe);
    repeat (8) @(negedge ref_clk);
    clr();
    repeat (3) ctl.tick(7'h01, 1'b0, q);
    repeat (8) @(negedge ref_clk);
    chk_n(cnt[2], et, "toggle steps");
    chk_n(cnt[4], er, "run steps");
    chk_n(cnt[3], (et + er > 0) ? 3 : 0, "output latches");
    chk_n(cnt[0] + cnt[1], 0, "idle capture");
    $display("idle test %h done", op);
  endtask

  task automatic test_run_op();
    for (int c = 0; c < 8; c++) begin
      control_op = 3'(c);
      repeat (3) @(negedge ref_clk);
      chk_v({5'h00, run_op_reg}, {5'h00, 3'(c)}, "run op");
    end
    $display("run op test done");
  endtask

  task automatic test_resets();
    logic [7:0] cap, oe;
    logic [1:0] q;
    ctl.ir_scan(8'h00, cap, oe);
    ctl.tick(7'h40, 1'b0, q);
    ctl.tick(7'h01, 1'b0, q);
    repeat (4) @(negedge ref_clk);
    chk_v(lv, 8'h40, "logic reset");
    chk_v({7'h00, bypass_bit_reg}, 8'h00, "reset bypass bit");
    ctl.ir_scan(8'h0C, cap, oe);
    sys_rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk_v(lv, 8'h40, "system reset");
    $display("reset test done");
  endtask

  initial begin
    sys_rst = 1'b1;
    dr_serial_out = 1'b1;
    control_op = 3'b000;
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk_v(lv, 8'h40, "after reset");
    test_table();
    test_idle(8'h8D, 3, 0);
    test_idle(8'h09, 0, 3);
    test_idle(8'h81, 0, 0);
    test_run_op();
    test_resets();
    give_verdict();
  end

  // Cuts a hang short well inside the run budget
  initial begin
    #2000000;
    n_fail++;
    give_verdict();
  end
endmodule
